// ---- i2c_target_pkg.sv ----
// constants, types and register map of the i2c target event and status block
// assumes an apb master on clk and open-drain scl/sda resolved outside
//
// Function
// - stop, start and data sources, each maskable
// - source mask takes any bit combination
// - only enabled sources reach the interrupt line
// - one overall interrupt enable gates output
// - raw and masked status both readable
// - one-bit summary, raw or masked as selected
// - action status idle when nothing requested
// - receive request while received byte uncollected
// - transmit request when read needs next byte
// - distinct code for first byte received after address
// - action status flags secondary address match
// - two own addresses, selector picks which
// - clear write removes selected pending sources
package i2c_target_pkg;

    localparam int          N_SRC      = 3;
    localparam int          SRC_STOP   = 0;
    localparam int          SRC_START  = 1;
    localparam int          SRC_DATA   = 2;
    localparam int          OWN_W      = 7;
    localparam int          SEL_BIT    = 8;
    localparam int          SEC_LSB    = 8;
    localparam int          CTRL_EN    = 0;
    localparam int          CTRL_IRQ   = 1;
    localparam int          CTRL_SEC   = 2;
    localparam int          SUM_BIT    = 0;
    localparam int          SEL_RD_BIT = 1;

    localparam logic [7:0]  OFS_ADDR   = 8'h00;
    localparam logic [7:0]  OFS_CTRL   = 8'h04;
    localparam logic [7:0]  OFS_MASK   = 8'h08;
    localparam logic [7:0]  OFS_RIS    = 8'h0C;
    localparam logic [7:0]  OFS_MIS    = 8'h10;
    localparam logic [7:0]  OFS_SUM    = 8'h14;
    localparam logic [7:0]  OFS_ACT    = 8'h18;
    localparam logic [7:0]  OFS_DATA   = 8'h1C;

    localparam logic [2:0]  BIT_LAST   = 3'h7;
    localparam logic [6:0]  OWN_RST    = 7'h00;
    localparam logic [2:0]  CTRL_RST   = 3'h0;
    localparam logic [2:0]  MASK_RST   = 3'h0;

    localparam logic [3:0]  act_idle               = 4'h0;
    localparam logic [3:0]  act_receive_request    = 4'h1;
    localparam logic [3:0]  act_transmit_request   = 4'h2;
    localparam logic [3:0]  act_receive_first_byte = 4'h5;
    localparam logic [3:0]  act_second_address_hit = 4'h8;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic second_hit;
        logic first_byte;
        logic tx_req;
        logic rx_req;
    } act_t;

    typedef enum {
        st_idle, st_addr, st_addr_ack, st_rx, st_rx_ack, st_tx_load, st_tx, st_tx_ack
    } eng_state_t;

endpackage : i2c_target_pkg

// ---- pin_sync.sv ----
// three-stage synchroniser for one bus pin with filtered edge pulses
// assumes pin idles high, as an open-drain bus line does
`timescale 1ns/10ps
module pin_sync (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk) begin
        if (srst) begin
            level <= 1'b1;
            rise  <= 1'b0;
            fall  <= 1'b0;
        end else begin
            rise  <= (s2 == s3) && s3 && !level;
            fall  <= (s2 == s3) && !s3 && level;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule : pin_sync

// ---- evt_latch.sv ----
// bank of sticky event flags, write-one-to-clear
// assumes set and clr are single-cycle terms on clk
`timescale 1ns/10ps
module evt_latch #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);
    for (genvar i = 0; i < W; i++) begin : g_flag
        // set beats a clear in the same cycle
        always_ff @(posedge clk) begin
            if (srst) begin
                q[i] <= 1'b0;
            end else if (set[i]) begin
                q[i] <= 1'b1;
            end else if (clr[i]) begin
                q[i] <= 1'b0;
            end
        end
    end
endmodule : evt_latch

// ---- i2c_target_event_status.sv ----
// i2c target: bus engine, event status, interrupt and action status behind apb
// assumes external pull-ups resolve scl/sda from the *_oe_n enables
`timescale 1ns/10ps
module i2c_target_event_status (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire i2c_target_pkg::apb_req_t apb,
    output logic                          pready,
    output logic [31:0]                   prdata,
    output logic                          pslverr,
    input  wire logic                     scl_i,
    output logic                          scl_o,
    output logic                          scl_oe_n,
    input  wire logic                     sda_i,
    output logic                          sda_o,
    output logic                          sda_oe_n,
    output logic                          irq
);
    import i2c_target_pkg::*;

    logic             scl_lvl;
    logic             scl_rise;
    logic             scl_fall;
    logic             sda_lvl;
    logic             sda_rise;
    logic             sda_fall;
    logic [OWN_W-1:0] own_addr [2];
    logic [2:0]       ctrl;
    logic [N_SRC-1:0] src_mask;
    logic             masked_select;
    logic [N_SRC-1:0] raw;
    logic [N_SRC-1:0] masked;
    logic [N_SRC-1:0] evt;
    logic [N_SRC-1:0] clr;
    logic [31:0]      rd_mux;
    act_t             act;
    eng_state_t       state;
    logic [2:0]       bit_cnt;
    logic [7:0]       shift;
    logic             ack_on;
    logic             rw;
    logic             mack;
    logic             second_hit;
    logic             first_pend;
    logic [7:0]       rx_data;
    logic             rx_full;
    logic             rx_first;
    logic [7:0]       tx_data;
    logic             tx_full;
    logic             tx_req_q;
    logic             en;
    logic             start_det;
    logic             stop_det;
    logic             eng_go;
    logic             hit0;
    logic             hit1;
    logic             rx_put;
    logic             tx_take;
    logic             tx_want;
    logic             setup;
    logic             wr;
    logic             rd;

    function automatic logic reg_is(input logic [31:0] a, input logic [7:0] ofs);
        return (a[31:8] == 24'h000000) && (a[7:0] == ofs);
    endfunction : reg_is

    function automatic logic mapped(input logic [31:0] a);
        return reg_is(a, OFS_ADDR) || reg_is(a, OFS_CTRL) || reg_is(a, OFS_MASK)
            || reg_is(a, OFS_RIS) || reg_is(a, OFS_MIS) || reg_is(a, OFS_SUM)
            || reg_is(a, OFS_ACT) || reg_is(a, OFS_DATA);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////////
    // pin sampling and bus conditions

    pin_sync u_scl (
        .clk   (clk),
        .srst  (srst),
        .pin   (scl_i),
        .level (scl_lvl),
        .rise  (scl_rise),
        .fall  (scl_fall)
    );

    pin_sync u_sda (
        .clk   (clk),
        .srst  (srst),
        .pin   (sda_i),
        .level (sda_lvl),
        .rise  (sda_rise),
        .fall  (sda_fall)
    );

    assign en        = ctrl[CTRL_EN];
    assign start_det = en && sda_fall && scl_lvl;
    assign stop_det  = en && sda_rise && scl_lvl;
    assign eng_go    = en && !start_det && !stop_det;
    assign hit0      = shift[OWN_W-1:0] == own_addr[0];
    assign hit1      = ctrl[CTRL_SEC] && (shift[OWN_W-1:0] == own_addr[1]);
    assign rx_put    = eng_go && (state == st_rx_ack) && !ack_on && !rx_full
                       && (scl_fall || !scl_oe_n);
    assign tx_take   = eng_go && (state == st_tx_load) && tx_full;
    assign tx_want   = (state == st_tx_load) && !tx_full;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: no wait state, answer in the first access cycle

    assign setup = apb.psel && !apb.penable;
    assign wr    = apb.psel && apb.penable && pready && apb.pwrite && !pslverr;
    assign rd    = apb.psel && apb.penable && pready && !apb.pwrite && !pslverr;

    always_comb begin
        rd_mux = '0;
        if (reg_is(apb.paddr, OFS_ADDR)) begin
            rd_mux[OWN_W-1:0]         = own_addr[0];
            rd_mux[SEC_LSB+:OWN_W]    = own_addr[1];
        end
        if (reg_is(apb.paddr, OFS_CTRL)) begin
            rd_mux[2:0] = ctrl;
        end
        if (reg_is(apb.paddr, OFS_MASK)) begin
            rd_mux[N_SRC-1:0] = src_mask;
        end
        if (reg_is(apb.paddr, OFS_RIS)) begin
            rd_mux[N_SRC-1:0] = raw;
        end
        if (reg_is(apb.paddr, OFS_MIS)) begin
            rd_mux[N_SRC-1:0] = masked;
        end
        if (reg_is(apb.paddr, OFS_SUM)) begin
            rd_mux[SUM_BIT]    = masked_select ? |masked : |raw;
            rd_mux[SEL_RD_BIT] = masked_select;
        end
        if (reg_is(apb.paddr, OFS_ACT)) begin
            rd_mux[3:0] = act;
        end
        if (reg_is(apb.paddr, OFS_DATA)) begin
            rd_mux[7:0] = rx_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped(apb.paddr);
            prdata  <= (setup && !apb.pwrite) ? rd_mux : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge clk) begin
        if (srst) begin
            own_addr[0] <= OWN_RST;
            own_addr[1] <= OWN_RST;
        end else if (wr && reg_is(apb.paddr, OFS_ADDR)) begin
            own_addr[apb.pwdata[SEL_BIT]] <= apb.pwdata[OWN_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl          <= CTRL_RST;
            src_mask      <= MASK_RST;
            masked_select <= 1'b0;
        end else if (wr) begin
            if (reg_is(apb.paddr, OFS_CTRL)) begin
                ctrl <= apb.pwdata[2:0];
            end
            if (reg_is(apb.paddr, OFS_MASK)) begin
                src_mask <= apb.pwdata[N_SRC-1:0];
            end
            if (reg_is(apb.paddr, OFS_SUM)) begin
                masked_select <= apb.pwdata[SUM_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event sources, sticky status and interrupt

    always_comb begin
        evt            = '0;
        evt[SRC_STOP]  = stop_det;
        evt[SRC_START] = start_det;
        evt[SRC_DATA]  = rx_put || (tx_want && !tx_req_q);
    end

    assign clr    = (wr && reg_is(apb.paddr, OFS_RIS)) ? apb.pwdata[N_SRC-1:0] : '0;
    assign masked = raw & src_mask;

    evt_latch #(
        .W (N_SRC)
    ) u_status (
        .clk  (clk),
        .srst (srst),
        .set  (evt),
        .clr  (clr),
        .q    (raw)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            irq      <= 1'b0;
            tx_req_q <= 1'b0;
        end else begin
            irq      <= ctrl[CTRL_IRQ] && (|masked);
            tx_req_q <= tx_want;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data holding registers and action status

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_data  <= '0;
            rx_full  <= 1'b0;
            rx_first <= 1'b0;
        end else if (rx_put) begin
            rx_data  <= shift;
            rx_full  <= 1'b1;
            rx_first <= first_pend;
        end else if (rd && reg_is(apb.paddr, OFS_DATA)) begin
            rx_full  <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_data <= '0;
            tx_full <= 1'b0;
        end else if (wr && reg_is(apb.paddr, OFS_DATA)) begin
            // a byte written as the old one is taken stays pending
            tx_data <= apb.pwdata[7:0];
            tx_full <= 1'b1;
        end else if (tx_take) begin
            tx_full <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            act <= act_idle;
        end else begin
            act.rx_req     <= rx_full;
            act.first_byte <= rx_full && rx_first;
            act.tx_req     <= tx_want;
            act.second_hit <= second_hit && (rx_full || tx_want);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus engine: address match, ack, receive and transmit with stretching

    always_ff @(posedge clk) begin
        if (srst) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state      <= st_idle;
            bit_cnt    <= '0;
            shift      <= '0;
            ack_on     <= 1'b0;
            rw         <= 1'b0;
            mack       <= 1'b0;
            second_hit <= 1'b0;
            first_pend <= 1'b0;
            sda_oe_n   <= 1'b1;
            scl_oe_n   <= 1'b1;
        end else if (!en || stop_det) begin
            state    <= st_idle;
            ack_on   <= 1'b0;
            sda_oe_n <= 1'b1;
            scl_oe_n <= 1'b1;
        end else if (start_det) begin
            state    <= st_addr;
            bit_cnt  <= '0;
            ack_on   <= 1'b0;
            sda_oe_n <= 1'b1;
            scl_oe_n <= 1'b1;
        end else begin
            unique case (state)
                st_idle: begin
                end
                st_addr: begin
                    if (scl_rise) begin
                        shift   <= {shift[6:0], sda_lvl};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == BIT_LAST) begin
                            state      <= (hit0 || hit1) ? st_addr_ack : st_idle;
                            rw         <= sda_lvl;
                            second_hit <= hit1 && !hit0;
                            first_pend <= 1'b1;
                        end
                    end
                end
                st_addr_ack: begin
                    if (scl_fall) begin
                        if (!ack_on) begin
                            sda_oe_n <= 1'b0;
                            ack_on   <= 1'b1;
                        end else begin
                            sda_oe_n <= 1'b1;
                            ack_on   <= 1'b0;
                            bit_cnt  <= '0;
                            state    <= rw ? st_tx_load : st_rx;
                        end
                    end
                end
                st_rx: begin
                    if (scl_rise) begin
                        shift   <= {shift[6:0], sda_lvl};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == BIT_LAST) begin
                            state <= st_rx_ack;
                        end
                    end
                end
                st_rx_ack: begin
                    // hold scl low until software has collected the previous byte
                    if (!ack_on) begin
                        if (rx_put) begin
                            sda_oe_n   <= 1'b0;
                            ack_on     <= 1'b1;
                            first_pend <= 1'b0;
                        end else if (scl_fall) begin
                            scl_oe_n <= 1'b0;
                        end
                    end else if (!scl_oe_n) begin
                        // sda settles a cycle before the stretch ends
                        scl_oe_n <= 1'b1;
                    end else if (scl_fall) begin
                        sda_oe_n <= 1'b1;
                        ack_on   <= 1'b0;
                        bit_cnt  <= '0;
                        state    <= st_rx;
                    end
                end
                st_tx_load: begin
                    if (tx_take) begin
                        shift    <= tx_data;
                        sda_oe_n <= tx_data[7];
                        bit_cnt  <= '0;
                        state    <= st_tx;
                    end else begin
                        scl_oe_n <= 1'b0;
                    end
                end
                st_tx: begin
                    if (!scl_oe_n) begin
                        scl_oe_n <= 1'b1;
                    end else if (scl_rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == BIT_LAST) begin
                            state <= st_tx_ack;
                        end
                    end else if (scl_fall) begin
                        sda_oe_n <= shift[6];
                        shift    <= {shift[6:0], 1'b0};
                    end
                end
                st_tx_ack: begin
                    if (scl_fall && !ack_on) begin
                        sda_oe_n <= 1'b1;
                        ack_on   <= 1'b1;
                    end else if (scl_rise && ack_on) begin
                        mack <= !sda_lvl;
                    end else if (scl_fall) begin
                        ack_on <= 1'b0;
                        state  <= mack ? st_tx_load : st_idle;
                    end
                end
            endcase
        end
    end
endmodule : i2c_target_event_status

// ---- i2c_target_event_status_monitor.sv ----
// checker: apb answer timing, interrupt gating and pin changes of the i2c target
// assumes one clock domain; bound to i2c_target_event_status below
`timescale 1ns/10ps
module i2c_target_event_status_monitor (
    input wire logic                     clk,
    input wire logic                     srst,
    input wire i2c_target_pkg::apb_req_t apb,
    input wire logic                     pready,
    input wire logic [31:0]              prdata,
    input wire logic                     pslverr,
    input wire logic                     scl_i,
    input wire logic                     sda_oe_n,
    input wire logic                     irq
);
    import i2c_target_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic wr_ok;
    assign wr_ok = apb.psel & apb.penable & pready & apb.pwrite;
    property p_answer;
        apb.psel && !apb.penable |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    property p_single;
        pready |=> !pready;
    endproperty
    a_single: assert property (p_single) else $error("ready longer than one cycle");
    property p_idle_zero;
        !pready |-> prdata == 32'h0;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data outside answer");
    property p_unmapped;
        apb.psel && !apb.penable && apb.paddr[31:8] != 24'h0 |=> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_ctrl_off;
        wr_ok && apb.paddr == {24'h0, OFS_CTRL} && !apb.pwdata[CTRL_IRQ] |-> ##2 !irq;
    endproperty
    a_ctrl_off: assert property (p_ctrl_off) else $error("irq with overall enable off");
    property p_mask_off;
        wr_ok && apb.paddr == {24'h0, OFS_MASK} && apb.pwdata[2:0] == 3'h0 |-> ##2 !irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq with all sources masked");
    property p_sda_move;
        $changed(sda_oe_n) |-> !scl_i;
    endproperty
    a_sda_move: assert property (p_sda_move) else $error("sda moved while scl high");
    property p_reset;
        disable iff (1'b0) srst |=> !irq && !pready;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs active in reset");
endmodule : i2c_target_event_status_monitor
bind i2c_target_event_status i2c_target_event_status_monitor i_mon (
    .clk(clk), .srst(srst), .apb(apb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .scl_i(scl_i), .sda_oe_n(sda_oe_n), .irq(irq));

// ---- i2c_ctrl_model.sv ----
// i2c bus controller model: open-drain scl/sda, 8 clk per third of a bit
// assumes pull-ups outside: a released line reads high
`timescale 1ns/10ps
module i2c_ctrl_model (
    input  wire logic clk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_m,
    output logic      sda_m
);
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    task automatic gap();
        repeat (8) @(posedge clk);
    endtask : gap
    // release scl, then wait while the target stretches it
    task automatic scl_up();
        int n;
        scl_m <= 1'b1;
        for (n = 0; n < 4000 && scl !== 1'b1; n++) @(posedge clk);
        gap();
    endtask : scl_up
    task automatic start();
        sda_m <= 1'b0;
        gap();
        scl_m <= 1'b0;
        gap();
    endtask : start
    task automatic stop();
        sda_m <= 1'b0;
        gap();
        scl_up();
        sda_m <= 1'b1;
        gap();
    endtask : stop
    task automatic bit_io(input logic b, output logic r);
        sda_m <= b;
        gap();
        scl_up();
        r = sda;
        scl_m <= 1'b0;
        gap();
    endtask : bit_io
    task automatic put_byte(input logic [7:0] d, output logic ack_n);
        logic x;
        for (int i = 7; i >= 0; i--) bit_io(d[i], x);
        bit_io(1'b1, ack_n);
    endtask : put_byte
    task automatic get_byte(input logic ack_n, output logic [7:0] d);
        logic x;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(ack_n, x);
    endtask : get_byte
endmodule : i2c_ctrl_model

// ---- i2c_target_event_status_tb_top.sv ----
// testbench: apb master, bus controller model and scenario tasks for the i2c target
// assumes the checker is bound in by its own file
`timescale 1ns/10ps
module i2c_target_event_status_tb_top;
    import i2c_target_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    apb_req_t    apb = '0;
    logic        pready, pslverr, irq, scl_o, scl_oe_n, sda_o, sda_oe_n;
    logic        scl_m, sda_m, last_err, ack_n;
    logic [31:0] prdata, q;
    logic [7:0]  d;
    wire logic   scl = scl_m & scl_oe_n;
    wire logic   sda = sda_m & sda_oe_n;
    int          err_total = 0;
    int          tests_run = 0;
    always #5 clk = ~clk;
    i2c_target_event_status i_dut (.clk(clk), .srst(srst), .apb(apb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .irq(irq));
    i2c_ctrl_model i_host (.clk(clk), .scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        apb.psel <= 1'b1;
        apb.penable <= 1'b0;
        apb.pwrite <= w;
        apb.paddr <= {24'h0, a};
        apb.pwdata <= wd;
        @(posedge clk);
        apb.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        last_err = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            results();
        end else begin
            @(posedge clk);
        end
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int a = 0; a <= 'h18; a += 4) rd(8'(a), 32'h0);
        rd(8'h20, 32'h0);
        chk({31'h0, last_err}, 32'h1);
    endtask : t_reset
    task automatic t_addr();
        xfer(1'b1, OFS_ADDR, 32'h0000_002A);
        xfer(1'b1, OFS_ADDR, 32'h0000_0133);
        rd(OFS_ADDR, 32'h0000_332A);
        xfer(1'b1, OFS_CTRL, 32'h7);
    endtask : t_addr
    task automatic t_write_xfer();
        i_host.start();
        i_host.put_byte(8'h54, ack_n);
        chk({31'h0, ack_n}, 32'h0);
        chk({30'h0, scl_o, sda_o}, 32'h0);
        i_host.put_byte(8'h55, ack_n);
        rd(OFS_RIS, 32'h6);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_ACT, {28'h0, act_receive_first_byte});
        rd(OFS_DATA, 32'h55);
        rd(OFS_ACT, {28'h0, act_idle});
        i_host.put_byte(8'hA3, ack_n);
        rd(OFS_ACT, {28'h0, act_receive_request});
        // next byte arrives with the previous one unread: target must stretch
        fork
            i_host.put_byte(8'h3C, ack_n);
            begin
                repeat (400) @(posedge clk);
                rd(OFS_DATA, 32'hA3);
            end
        join
        chk({31'h0, ack_n}, 32'h0);
        rd(OFS_DATA, 32'h3C);
        i_host.stop();
        rd(OFS_RIS, 32'h7);
    endtask : t_write_xfer
    task automatic t_masks();
        xfer(1'b1, OFS_SUM, 32'h1);
        for (int m = 0; m < 8; m++) begin
            xfer(1'b1, OFS_MASK, 32'(m));
            rd(OFS_MIS, 32'(m));
            repeat (3) @(posedge clk);
            chk({31'h0, irq}, {31'h0, m != 0});
            rd(OFS_SUM, {30'h0, 1'b1, m != 0});
        end
        xfer(1'b1, OFS_CTRL, 32'h5);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, OFS_RIS, 32'h5);
        rd(OFS_RIS, 32'h2);
        xfer(1'b1, OFS_SUM, 32'h0);
        rd(OFS_SUM, 32'h1);
        xfer(1'b1, OFS_RIS, 32'h2);
        rd(OFS_RIS, 32'h0);
    endtask : t_masks
    task automatic t_read_xfer();
        int n;
        i_host.start();
        i_host.put_byte(8'h67, ack_n);
        chk({31'h0, ack_n}, 32'h0);
        fork
            i_host.get_byte(1'b1, d);
            begin
                q = 32'h0;
                for (n = 0; n < 800 && q === 32'h0; n++) xfer(1'b0, OFS_ACT, 32'h0);
                chk(q, {28'h0, act_transmit_request | act_second_address_hit});
                xfer(1'b1, OFS_DATA, 32'hC6);
            end
        join
        chk({24'h0, d}, 32'hC6);
        i_host.stop();
    endtask : t_read_xfer
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_addr();
        t_write_xfer();
        t_masks();
        t_read_xfer();
        results();
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        results();
    end
endmodule : i2c_target_event_status_tb_top
